// file: src/sr4_shift_load_top.sv
// Top of the four-stage shift/load register with tristate-style outputs
// What this block does
// - Holds four edge-triggered stages whose contents appear on four outputs.
// - Stages change only on a falling edge of the register clock pin or on a clear.
// - Data, serial and mode inputs are sampled only at that falling edge.
// - Mode select high loads stage n from parallel input n.
// - Mode select low shifts right, serial input feeding the first stage.
// - On a shift stage zero moves to one, one to two, two to three.
// - On a shift the first stage takes the serial input level.
// - Clear low zeroes all stages at once, overriding load and shift.
// - Output control high disables the four outputs; low drives stage values.
// - Output control leaves load, shift, clear and cascade output untouched.
// - A never-disabled copy of stage three allows chaining devices.
`timescale 1ns/1ps
module sr4_shift_load_top (
  input  wire logic       core_clk_in,           // Core clock, 250 MHz
  input  wire logic       rst_n_in,              // Synchronous reset, active low
  input  wire logic       falling_edge_clock_in, // Register clock pin, acts on fall
  input  wire logic       master_clear_n_in,     // Clear pin, active low
  input  wire logic       output_control_in,     // High disables data outputs
  input  wire logic       mode_select_in,        // High load, low shift
  input  wire logic       serial_in,             // Serial data for stage 0
  input  wire logic [3:0] parallel_in,           // Parallel data, bit n to stage n
  input  wire logic       drain_hold_in,         // Stall applying queued edges
  output logic      [3:0] tristate_outputs_out,  // Stage values
  output logic            tristate_oe_n_out,     // Low while outputs are driven
  output logic            cascade_out,           // Stage 3, always driven
  output logic            cmd_ready_out,         // Edge queue can take an entry
  output logic            overrun_out            // Sticky: an edge was lost
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [sr4_pkg::PIN_W-1:0] pins;
  logic [sr4_pkg::PIN_W-1:0] sync1_ff, nxt_sync1;
  logic [sr4_pkg::PIN_W-1:0] sync2_ff, nxt_sync2;

  assign pins = {falling_edge_clock_in, master_clear_n_in, output_control_in,
                 mode_select_in, serial_in, parallel_in};

  // First stage feeds only the second stage
  always_comb begin
    nxt_sync1 = pins;
    nxt_sync2 = sync1_ff;
  end

  // Reset shows clock idle, clear asserted, outputs disabled
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_ff <= sr4_pkg::PIN_RST;
      sync2_ff <= sr4_pkg::PIN_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ----------------------------------------------------------------
  // Falling edge detection and sampling
  // ----------------------------------------------------------------
  logic clk_prev_ff, nxt_clk_prev;
  logic clk_fall;
  logic clr_act;

  // Previous level starts high so reset release is never a false edge
  always_comb begin
    nxt_clk_prev = sync2_ff[sr4_pkg::PIN_CLK];
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      clk_prev_ff <= 1'b1;
    end else begin
      clk_prev_ff <= nxt_clk_prev;
    end
  end

  // Only a high-to-low step counts; rising edges do nothing
  assign clk_fall = clk_prev_ff && !sync2_ff[sr4_pkg::PIN_CLK];
  assign clr_act  = !sync2_ff[sr4_pkg::PIN_CLR];

  // ----------------------------------------------------------------
  // Edge queue
  // ----------------------------------------------------------------
  sr4_cmd_if #(.W(sr4_pkg::CMD_W)) push_if ();
  sr4_cmd_if #(.W(sr4_pkg::CMD_W)) pop_if ();

  // Inputs captured in the same cycle the fall is seen; all pins share
  // one synchroniser depth, so the sample matches the pin at the edge
  assign push_if.valid = clk_fall && !clr_act;
  assign push_if.data  = {sync2_ff[sr4_pkg::PIN_SEL],
                          sync2_ff[sr4_pkg::PIN_SER],
                          sync2_ff[sr4_pkg::PIN_PAR_LSB +: sr4_pkg::STAGE_N]};
  assign cmd_ready_out = push_if.ready;

  sr4_cmd_fifo #(
    .W     (sr4_pkg::CMD_W),
    .DEPTH (sr4_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .flush_in    (clr_act),
    .wr          (push_if.snk),
    .rd          (pop_if.src)
  );

  // ----------------------------------------------------------------
  // Stage core
  // ----------------------------------------------------------------
  sr4_pkg::sr4_stage_t stage_q;
  logic                pop_fire;

  sr4_stage_core u_core (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clear_in    (clr_act),
    .hold_in     (drain_hold_in),
    .cmd         (pop_if.snk),
    .stage_out   (stage_q)
  );

  // Word handed to the core this cycle
  assign pop_fire = pop_if.valid && pop_if.ready;

  // ----------------------------------------------------------------
  // Overrun flag
  // ----------------------------------------------------------------
  logic overrun_ff, nxt_overrun;
  logic drop;

  // A full queue cannot stall the pin, so the loss is made visible
  assign drop = push_if.valid && !push_if.ready;

  // Set wins over clear
  always_comb begin
    nxt_overrun = overrun_ff;
    if (drop) begin
      nxt_overrun = 1'b1;
    end else if (clr_act) begin
      nxt_overrun = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= nxt_overrun;
    end
  end

  assign overrun_out = overrun_ff;

  // ----------------------------------------------------------------
  // Output enable
  // ----------------------------------------------------------------
  logic oe_n_ff, nxt_oe_n;

  // Enable is its own signal; the data path never looks at it
  always_comb begin
    nxt_oe_n = sync2_ff[sr4_pkg::PIN_OC];
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= nxt_oe_n;
    end
  end

  // Data and cascade come straight off the stage flops
  assign tristate_oe_n_out    = oe_n_ff;
  assign tristate_outputs_out = stage_q;
  assign cascade_out          = stage_q[sr4_pkg::STAGE_N-1];

  // ----------------------------------------------------------------
  // Checks: sampling at the register clock pin
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // A sample with no fall would be a spurious update
  chk_edge_gate: assert property (
    push_if.valid |-> clk_fall)
    else $error("sample taken without a falling edge");

  // Every fall outside clear reaches the queue
  chk_fall_push: assert property (
    clk_fall && !clr_act |-> push_if.valid)
    else $error("falling edge was not sampled");

  // Rising edges stay silent
  chk_rise_idle: assert property (
    $rose(sync2_ff[sr4_pkg::PIN_CLK]) |-> !push_if.valid)
    else $error("rising edge produced a sample");

  // A long low level is still one event
  chk_fall_once: assert property (
    clk_fall |=> !clk_fall)
    else $error("one falling edge sampled twice");

  // Queued mode and serial bits are the levels seen with the fall
  chk_push_word: assert property (
    push_if.valid |-> sr4_pkg::cmd_sel(push_if.data) == sync2_ff[sr4_pkg::PIN_SEL]
      && sr4_pkg::cmd_ser(push_if.data) == sync2_ff[sr4_pkg::PIN_SER])
    else $error("queued word does not match the sampled pins");

  // Outputs move only on an applied edge or a clear
  chk_idle_stages: assert property (
    !pop_fire && !clr_act |=> $stable(tristate_outputs_out))
    else $error("outputs changed with no applied edge");

  // ----------------------------------------------------------------
  // Checks: load, shift and clear at the outputs
  // ----------------------------------------------------------------
  // Load puts the parallel word on the outputs
  chk_load_out: assert property (
    pop_fire && !clr_act && sr4_pkg::cmd_sel(pop_if.data)
    |=> tristate_outputs_out == sr4_pkg::cmd_par($past(pop_if.data)))
    else $error("outputs did not take the parallel word");

  // Shift moves each stage up by one
  chk_shift_out: assert property (
    pop_fire && !clr_act && !sr4_pkg::cmd_sel(pop_if.data)
    |=> tristate_outputs_out[3:1] == $past(tristate_outputs_out[2:0]))
    else $error("outputs did not shift right");

  // Serial level lands in the first stage
  chk_serial_out: assert property (
    pop_fire && !clr_act && !sr4_pkg::cmd_sel(pop_if.data)
    |=> tristate_outputs_out[0] == sr4_pkg::cmd_ser($past(pop_if.data)))
    else $error("first output does not follow serial input");

  // Clear reaches both outputs a cycle after it is seen
  chk_clear_path: assert property (
    clr_act |=> tristate_outputs_out == sr4_pkg::STAGE_RST && !cascade_out)
    else $error("clear did not reach the outputs");

  // No queue traffic while clearing
  chk_clear_block: assert property (
    clr_act |-> !push_if.valid && !pop_fire && !cmd_ready_out)
    else $error("queue traffic while clear is active");

  // A lost edge is flagged next cycle
  chk_overrun_set: assert property (
    drop |=> overrun_out)
    else $error("lost edge not flagged");

  // Flag stays up until the clear pin
  chk_overrun_keep: assert property (
    overrun_out && !clr_act |=> overrun_out)
    else $error("overrun flag dropped without clear");

  // Clear takes the flag down
  chk_overrun_clr: assert property (
    clr_act |=> !overrun_out)
    else $error("overrun flag not cleared");

  // ----------------------------------------------------------------
  // Checks: output control and cascade
  // ----------------------------------------------------------------
  // Enable follows the synchronised control pin
  chk_oe_track: assert property (
    sync2_ff[sr4_pkg::PIN_OC] |=> tristate_oe_n_out)
    else $error("outputs not disabled by output control");

  // Control low drives the outputs
  chk_oe_drive: assert property (
    !sync2_ff[sr4_pkg::PIN_OC] |=> !tristate_oe_n_out)
    else $error("outputs not driven with output control low");

  // Toggling output control alone leaves the stages
  chk_oc_isolate: assert property (
    $changed(sync2_ff[sr4_pkg::PIN_OC]) && !pop_fire && !clr_act |=> $stable(stage_q))
    else $error("output control disturbed the stage values");

  // Loads go on while the outputs are disabled
  chk_oc_load: assert property (
    tristate_oe_n_out && pop_fire && !clr_act && sr4_pkg::cmd_sel(pop_if.data)
    |=> tristate_outputs_out == sr4_pkg::cmd_par($past(pop_if.data)))
    else $error("load lost while outputs disabled");

  // Cascade takes the old stage two on a shift
  chk_cascade_tap: assert property (
    pop_fire && !clr_act && !sr4_pkg::cmd_sel(pop_if.data)
    |=> cascade_out == $past(stage_q[2]))
    else $error("cascade output did not follow stage two");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  cov_load:  cover property (pop_if.valid && pop_if.ready && pop_if.data[sr4_pkg::CMD_SEL_BIT]);
  cov_shift: cover property (pop_if.valid && pop_if.ready && !pop_if.data[sr4_pkg::CMD_SEL_BIT]);
  cov_clear: cover property ($fell(master_clear_n_in) ##[1:8] clr_act);
  cov_full:  cover property (!push_if.ready && !clr_act);
  cov_dark:  cover property (tristate_oe_n_out && pop_fire && sr4_pkg::cmd_sel(pop_if.data));

endmodule : sr4_shift_load_top

// file: include/sr4_pkg.sv
// Shared constants, types and command field helpers for the four-stage shift/load register
package sr4_pkg;

  // ----------------------------------------------------------------
  // Register geometry
  // ----------------------------------------------------------------
  localparam int unsigned STAGE_N    = 4;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [3:0]  STAGE_RST  = 4'h0;

  typedef logic [STAGE_N-1:0] sr4_stage_t;

  // ----------------------------------------------------------------
  // Command word: one sampled falling clock edge
  // ----------------------------------------------------------------
  localparam int unsigned CMD_W       = 6;
  localparam int unsigned CMD_PAR_LSB = 0;
  localparam int unsigned CMD_SER_BIT = 4;
  localparam int unsigned CMD_SEL_BIT = 5;

  typedef logic [CMD_W-1:0] sr4_cmd_t;

  // ----------------------------------------------------------------
  // Pin bundle order inside the input synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned PIN_W       = 9;
  localparam int unsigned PIN_PAR_LSB = 0;
  localparam int unsigned PIN_SER     = 4;
  localparam int unsigned PIN_SEL     = 5;
  localparam int unsigned PIN_OC      = 6;
  localparam int unsigned PIN_CLR     = 7;
  localparam int unsigned PIN_CLK     = 8;
  // Clock idle high, clear asserted, outputs disabled
  localparam logic [8:0]  PIN_RST     = 9'h140;

  // ----------------------------------------------------------------
  // Field helpers
  // ----------------------------------------------------------------
  function automatic sr4_stage_t cmd_par(input sr4_cmd_t c);
    return c[CMD_PAR_LSB +: STAGE_N];
  endfunction : cmd_par

  function automatic logic cmd_ser(input sr4_cmd_t c);
    return c[CMD_SER_BIT];
  endfunction : cmd_ser

  function automatic logic cmd_sel(input sr4_cmd_t c);
    return c[CMD_SEL_BIT];
  endfunction : cmd_sel

endpackage : sr4_pkg

// file: include/sr4_cmd_if.sv
// Valid/ready command carrier between the front end, the FIFO and the stage core
`timescale 1ns/1ps
interface sr4_cmd_if #(
  parameter int unsigned W = 6
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sr4_cmd_if

// file: src/sr4_cmd_fifo.sv
// Flip-flop FIFO with parameter width and depth, valid/ready on both sides
`timescale 1ns/1ps
module sr4_cmd_fifo #(
  parameter int unsigned W     = 6,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic  core_clk_in, // Core clock
  input  wire logic  rst_n_in,    // Synchronous reset, active low
  input  wire logic  flush_in,    // Drop all held words
  sr4_cmd_if.snk     wr,          // Filling side
  sr4_cmd_if.src     rd           // Draining side
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          wr_fire;
  logic          rd_fire;

  // ----------------------------------------------------------------
  // Handshakes: full and empty straight from the count
  // ----------------------------------------------------------------
  assign wr.ready = (cnt_ff != (AW+1)'(DEPTH)) && !flush_in;
  assign rd.valid = (cnt_ff != '0) && !flush_in;
  assign rd.data  = mem_ff[rd_ptr_ff];
  assign wr_fire  = wr.valid && wr.ready;
  assign rd_fire  = rd.valid && rd.ready;

  // Pointer and count next values; flush wins over traffic
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt    = cnt_ff;
    if (flush_in) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_cnt    = '0;
    end else begin
      if (wr_fire) begin
        nxt_wr_ptr = wr_ptr_ff + AW'(1);
      end
      if (rd_fire) begin
        nxt_rd_ptr = rd_ptr_ff + AW'(1);
      end
      nxt_cnt = cnt_ff + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
    end
  end

  // Pointer and count registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  // Storage needs no reset; unread words are never shown as valid
  always_ff @(posedge core_clk_in) begin
    if (wr_fire) begin
      mem_ff[wr_ptr_ff] <= wr.data;
    end
  end

endmodule : sr4_cmd_fifo

// file: src/sr4_stage_core.sv
// Four storage stages applying one load or right-shift command per accepted word
`timescale 1ns/1ps
module sr4_stage_core (
  input  wire logic               core_clk_in, // Core clock
  input  wire logic               rst_n_in,    // Synchronous reset, active low
  input  wire logic               clear_in,    // Master clear, active high here
  input  wire logic               hold_in,     // Stall the draining side
  sr4_cmd_if.snk                  cmd,         // Sampled edge commands
  output sr4_pkg::sr4_stage_t     stage_out    // Stage 0 in bit 0
);

  sr4_pkg::sr4_stage_t stage_ff, nxt_stage;
  logic                fire;

  // A stalled core leaves words in the FIFO so it can really fill
  assign cmd.ready = !hold_in;
  assign fire      = cmd.valid && cmd.ready;
  assign stage_out = stage_ff;

  // Clear beats load and shift; otherwise one step per command
  always_comb begin
    nxt_stage = stage_ff;
    if (clear_in) begin
      nxt_stage = sr4_pkg::STAGE_RST;
    end else if (fire) begin
      if (sr4_pkg::cmd_sel(cmd.data)) begin
        nxt_stage = sr4_pkg::cmd_par(cmd.data);
      end else begin
        nxt_stage = {stage_ff[2:0], sr4_pkg::cmd_ser(cmd.data)};
      end
    end
  end

  // Four edge-triggered stages
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stage_ff <= sr4_pkg::STAGE_RST;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_load_par: assert property (
    fire && !clear_in && sr4_pkg::cmd_sel(cmd.data)
    |=> stage_ff == sr4_pkg::cmd_par($past(cmd.data)))
    else $error("parallel load did not take the parallel inputs");

  chk_shift_move: assert property (
    fire && !clear_in && !sr4_pkg::cmd_sel(cmd.data)
    |=> stage_ff[3:1] == $past(stage_ff[2:0]))
    else $error("right shift did not move stages up by one");

  chk_first_stage: assert property (
    fire && !clear_in && !sr4_pkg::cmd_sel(cmd.data)
    |=> stage_ff[0] == sr4_pkg::cmd_ser($past(cmd.data)))
    else $error("first stage does not follow serial input");

  chk_clear_zero: assert property (
    clear_in |=> stage_ff == sr4_pkg::STAGE_RST)
    else $error("clear did not zero the stages");

  chk_hold_steady: assert property (
    !fire && !clear_in |=> $stable(stage_ff))
    else $error("stages changed without a command");

endmodule : sr4_stage_core

// file: bench/sr4_pin_drv.sv
// Model of the logic around the register: drives its clock, mode and data pins
`timescale 1ns/1ps
module sr4_pin_drv (
  input  wire logic       core_clk_in, // Core clock
  input  wire logic [3:0] q_in,        // Register outputs fed back
  output logic            clk_pin_out, // Register clock pin, idles high
  output logic            sel_out,     // Mode select pin
  output logic            ser_out,     // Serial data pin
  output logic      [3:0] par_out,     // Parallel data pins
  output logic            done_out     // One cycle: result has settled
);
  // Pin levels at time zero
  initial begin
    clk_pin_out = 1'b1;
    sel_out     = 1'b0;
    ser_out     = 1'b0;
    par_out     = 4'h0;
    done_out    = 1'b0;
  end

  // Past hold time the pins show the inverse, never a stale copy
  task automatic scramble;
    begin
      sel_out <= ~sel_out;
      ser_out <= ~ser_out;
      par_out <= ~par_out;
    end
  endtask : scramble

  // One pin cycle: 3 cycles setup, 5 low, then the rise and settling
  task automatic pin_cycle(input logic s, input logic d, input logic [3:0] p,
                           input logic lsh, input logic chk);
    begin
      @(negedge core_clk_in);
      sel_out <= lsh | s;
      ser_out <= d;
      par_out <= lsh ? {d, q_in[3:1]} : p;
      repeat (3) @(negedge core_clk_in);
      clk_pin_out <= 1'b0;
      repeat (4) @(negedge core_clk_in);
      scramble();
      // Rise comes with wrong data, so a rising-edge update would show
      @(negedge core_clk_in);
      clk_pin_out <= 1'b1;
      repeat (6) @(negedge core_clk_in);
      done_out <= chk;
      @(negedge core_clk_in);
      done_out <= 1'b0;
    end
  endtask : pin_cycle

  // Data and mode wander while the clock pin stands still
  task automatic wander(input int n);
    begin
      repeat (n) begin
        @(negedge core_clk_in);
        {sel_out, ser_out, par_out} <= 6'($urandom);
      end
    end
  endtask : wander
endmodule : sr4_pin_drv

// file: bench/sr4_shift_load_top_bench.sv
// Self-checking bench for the four-stage shift/load register
`timescale 1ns/1ps
`define SR4_EQ(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module sr4_shift_load_top_bench;
  logic       core_clk_in;
  logic       rst_n_in;
  logic       clk_pin;
  logic       master_clear_n_in;
  logic       output_control_in;
  logic       mode_select_in;
  logic       serial_in;
  logic [3:0] parallel_in;
  logic       drain_hold_in;
  logic [3:0] tristate_outputs_out;
  logic       tristate_oe_n_out;
  logic       cascade_out;
  logic       cmd_ready_out;
  logic       overrun_out;
  logic       done;
  logic [3:0] model;
  logic [3:0] keep;
  logic [3:0] exp_v;
  logic [3:0] expq[$];
  int         bad_count;
  int         compares;
  int         cyc;
  int         i;

  // ----------------------------------------------------------------
  // Clock, design and pin-side partner
  // ----------------------------------------------------------------
  initial core_clk_in = 1'b0;
  always #2 core_clk_in = ~core_clk_in;

  sr4_shift_load_top u_dut (
    .core_clk_in          (core_clk_in),
    .rst_n_in             (rst_n_in),
    .falling_edge_clock_in(clk_pin),
    .master_clear_n_in    (master_clear_n_in),
    .output_control_in    (output_control_in),
    .mode_select_in       (mode_select_in),
    .serial_in            (serial_in),
    .parallel_in          (parallel_in),
    .drain_hold_in        (drain_hold_in),
    .tristate_outputs_out (tristate_outputs_out),
    .tristate_oe_n_out    (tristate_oe_n_out),
    .cascade_out          (cascade_out),
    .cmd_ready_out        (cmd_ready_out),
    .overrun_out          (overrun_out)
  );

  sr4_pin_drv u_drv (
    .core_clk_in(core_clk_in),
    .q_in       (tristate_outputs_out),
    .clk_pin_out(clk_pin),
    .sel_out    (mode_select_in),
    .ser_out    (serial_in),
    .par_out    (parallel_in),
    .done_out   (done)
  );

  // ----------------------------------------------------------------
  // Verdict, hang limit and result watcher
  // ----------------------------------------------------------------
  task automatic complete_run;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask : complete_run

  // Whole run needs about 1000 cycles; 6000 leaves ample margin
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  // Oldest note is matched against each settled result
  always @(posedge core_clk_in) begin
    if (done) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 4'hx;
      `SR4_EQ("stages", exp_v, tristate_outputs_out)
      `SR4_EQ("cascade", exp_v[3], cascade_out)
    end
  end

  // Note the expected stages, then run one pin cycle
  task automatic do_cmd(input logic s, input logic d, input logic [3:0] p,
                        input logic lsh, input logic chk);
    begin
      if (lsh) model = {d, model[3:1]};
      else if (s) model = p;
      else model = {model[2:0], d};
      if (chk) expq.push_back(model);
      u_drv.pin_cycle(s, d, p, lsh, chk);
    end
  endtask : do_cmd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    master_clear_n_in = 1'b1;
    output_control_in = 1'b0;
    drain_hold_in = 1'b0;
    model = 4'h0;
    void'($urandom(32'h55e7));
    repeat (6) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge core_clk_in);
    `SR4_EQ("reset stages", 4'h0, tristate_outputs_out);
    `SR4_EQ("reset overrun", 1'b0, overrun_out);
    `SR4_EQ("reset ready", 1'b1, cmd_ready_out);
    `SR4_EQ("driven", 1'b0, tristate_oe_n_out);
    // Every mode and serial level, random parallel words
    for (i = 0; i < 16; i++) do_cmd(i[0], i[1], 4'($urandom), 1'b0, 1'b1);
    for (i = 0; i < 4; i++) do_cmd(1'b1, 1'($urandom), 4'h0, 1'b1, 1'b1);
    // Pins move with the clock pin steady: nothing may change
    keep = tristate_outputs_out;
    u_drv.wander(12);
    repeat (6) @(negedge core_clk_in);
    `SR4_EQ("steady pins", keep, tristate_outputs_out);
    // Outputs disabled: loading and shifting go on regardless
    output_control_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    `SR4_EQ("disabled", 1'b1, tristate_oe_n_out);
    do_cmd(1'b1, 1'b0, 4'h9, 1'b0, 1'b1);
    do_cmd(1'b0, 1'b1, 4'h0, 1'b0, 1'b1);
    output_control_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    `SR4_EQ("enabled", 1'b0, tristate_oe_n_out);
    // Clear overrides, and a fall during clear is ignored
    master_clear_n_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    `SR4_EQ("clear stages", 4'h0, tristate_outputs_out);
    `SR4_EQ("clear cascade", 1'b0, cascade_out);
    do_cmd(1'b1, 1'b1, 4'hf, 1'b0, 1'b0);
    `SR4_EQ("clear held", 4'h0, tristate_outputs_out);
    master_clear_n_in = 1'b1;
    model = 4'h0;
    repeat (4) @(negedge core_clk_in);
    // Fill the edge queue while the drain stalls, then overflow it
    drain_hold_in = 1'b1;
    for (i = 0; i < 34; i++) begin
      if (i == 32) begin
        `SR4_EQ("queue full", 1'b0, cmd_ready_out);
        keep = model;
      end
      do_cmd(1'b0, 1'($urandom), 4'h0, 1'b0, 1'b0);
    end
    model = keep;
    repeat (2) @(negedge core_clk_in);
    `SR4_EQ("overrun", 1'b1, overrun_out);
    drain_hold_in = 1'b0;
    repeat (50) @(negedge core_clk_in);
    `SR4_EQ("drained", model, tristate_outputs_out);
    `SR4_EQ("room again", 1'b1, cmd_ready_out);
    master_clear_n_in = 1'b0;
    repeat (5) @(negedge core_clk_in);
    `SR4_EQ("overrun cleared", 1'b0, overrun_out);
    master_clear_n_in = 1'b1;
    repeat (10) @(negedge core_clk_in);
    `SR4_EQ("notes left", 0, expq.size());
    complete_run();
  end
endmodule : sr4_shift_load_top_bench
